/* File: shared/vfm_pkg.sv */
package vfm_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_NOISE = 8'h04;
    localparam logic [7:0] OFS_FRZ_DUR = 8'h08;
    localparam logic [7:0] OFS_BLK_DUR = 8'h0c;
    localparam logic [7:0] OFS_POLL = 8'h10;
    localparam logic [7:0] OFS_STAMP = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_CMD = 8'h24;
    // CTRL fields
    localparam int CTRL_FAULT_LOG_BIT = 0;
    localparam int CTRL_STATUS_LOG_BIT = 1;
    localparam int CTRL_STAMP_VITC_BIT = 2;
    // CMD fields (write-only pulses)
    localparam int CMD_QUERY_BIT = 0;
    localparam int CMD_CLEAR_BIT = 1;
    // Interrupt status fields
    localparam int IRQ_FRZ_BIT = 0;
    localparam int IRQ_BLK_BIT = 1;
    localparam int IRQ_MSG_BIT = 2;
    // Limits and defaults
    localparam logic [3:0] NOISE_MIN = 4'h1;
    localparam logic [3:0] NOISE_MAX = 4'ha;
    localparam logic [3:0] NOISE_RST = 4'h9;
    localparam logic [9:0] FRZ_MIN = 10'h006;
    localparam logic [9:0] FRZ_MAX = 10'h386;
    localparam logic [9:0] FRZ_RST = 10'h12e;
    localparam logic [9:0] BLK_MIN = 10'h004;
    localparam logic [9:0] BLK_MAX = 10'h384;
    localparam logic [9:0] BLK_RST = 10'h058;
    localparam logic [5:0] POLL_MIN = 6'h01;
    localparam logic [5:0] POLL_MAX = 6'h3c;
    localparam logic [5:0] POLL_RST = 6'h01;
    // Stamp clock: frames per second, last second or minute value, last hour value
    localparam logic [7:0] STAMP_FPS = 8'h1e;
    localparam logic [7:0] STAMP_SEC_LAST = 8'h3b;
    localparam logic [7:0] STAMP_HOUR_LAST = 8'h17;
    // Black level 7 IRE on a 10-bit luma scale (64 = 0 IRE, 940 = 100 IRE)
    localparam int BLACK_IRE = 7;
    localparam logic [9:0] LUMA_ZERO = 10'h040;
    localparam logic [9:0] LUMA_SPAN = 10'h36c;
    localparam logic [9:0] BLACK_LEVEL = LUMA_ZERO + 10'((BLACK_IRE * int'(LUMA_SPAN)) / 100);
    // Activity per threshold step, scaled so step 10 sits at about 40 dB SNR
    localparam logic [23:0] NOISE_STEP = 24'h000400;
    // Clock and time base
    localparam int CLK_HZ = 250_000_000;
    localparam int MINUTE_S = 60;
    localparam int SECOND_TICKS = CLK_HZ;
    // Message kinds
    typedef enum logic [1:0] {VFM_MSG_STATUS, VFM_MSG_FAULT} vfm_msg_e;
endpackage

/* File: hdl/vfm_dur_detect.sv */
// Counts consecutive frames meeting a condition and raises a fault at the limit
module vfm_dur_detect (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic frame_end,
    input wire logic cond,
    input wire logic [9:0] limit,
    input wire logic clear,
    output logic fault
);
    logic [9:0] cnt_ff;
    logic fault_ff;

    // Only consecutive qualifying frames accumulate; any other frame restarts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 10'h000;
        end else if (clear) begin
            cnt_ff <= 10'h000;
        end else if (frame_end) begin
            if (!cond) begin
                cnt_ff <= 10'h000;
            end else if (cnt_ff < limit) begin
                cnt_ff <= cnt_ff + 10'h001;
            end
        end
    end

    // Fault holds while the condition persists, drops on a clean frame or clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fault_ff <= 1'b0;
        end else if (clear) begin
            fault_ff <= 1'b0;
        end else if (frame_end) begin
            fault_ff <= cond && (cnt_ff + 10'h001 >= limit);
        end
    end

    assign fault = fault_ff;

    a_fault_needs_cond: assert property (@(posedge ref_clk) disable iff (rst)
        (frame_end && !cond && !clear) |=> !fault) else $error("Fault set after clean frame");
    a_clear_drops_fault: assert property (@(posedge ref_clk) disable iff (rst)
        clear |=> !fault) else $error("Fault survived clear");
endmodule // vfm_dur_detect

/* File: hdl/vfm_stamp_clock.sv */
// Free-running time-of-day clock: hh:mm:ss:ff, loadable by software
module vfm_stamp_clock (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic frame_end,
    input wire logic load,
    input wire logic [31:0] load_val,
    output logic [31:0] stamp
);
    logic [31:0] tc_ff;

    // Advances one frame per frame pulse; load takes priority
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tc_ff <= 32'h0000_0000;
        end else if (load) begin
            tc_ff <= load_val;
        end else if (frame_end) begin
            if (tc_ff[7:0] + 8'h01 < vfm_pkg::STAMP_FPS) begin
                tc_ff[7:0] <= tc_ff[7:0] + 8'h01;
            end else begin
                tc_ff[7:0] <= 8'h00;
                if (tc_ff[15:8] < vfm_pkg::STAMP_SEC_LAST) begin
                    tc_ff[15:8] <= tc_ff[15:8] + 8'h01;
                end else begin
                    tc_ff[15:8] <= 8'h00;
                    if (tc_ff[23:16] < vfm_pkg::STAMP_SEC_LAST) begin
                        tc_ff[23:16] <= tc_ff[23:16] + 8'h01;
                    end else begin
                        tc_ff[23:16] <= 8'h00;
                        tc_ff[31:24] <= (tc_ff[31:24] < vfm_pkg::STAMP_HOUR_LAST) ? tc_ff[31:24] + 8'h01 : 8'h00;
                    end
                end
            end
        end
    end

    assign stamp = tc_ff;

    a_load_takes: assert property (@(posedge ref_clk) disable iff (rst)
        load |=> stamp == $past(load_val)) else $error("Stamp load lost");
endmodule // vfm_stamp_clock

/* File: hdl/vfm_monitor.sv */
// Video fault monitor and logger: freeze and black detection, status and fault messages
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module vfm_monitor (
    input wire logic REF_CLK,
    input wire logic RST,
    // Per-frame measurements from the video front end
    input wire logic FRAME_END,
    input wire logic [23:0] FRAME_ACTIVITY,
    input wire logic [9:0] PEAK_LUMA,
    input wire logic VITC_VALID,
    input wire logic [31:0] VITC_TIME,
    // Other status items reported verbatim
    input wire logic [15:0] STATUS_ITEMS,
    input wire logic EDH_AP_ERR,
    input wire logic EDH_FF_ERR,
    input wire logic AUDIO_FMT_ERR,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Message output towards the serial formatter, then the fault flags and the interrupt
    output logic MSG_VALID,
    input wire logic MSG_READY,
    output logic [1:0] MSG_KIND,
    output logic [31:0] MSG_STAMP,
    output logic [23:0] MSG_DATA,
    output logic FREEZE_FAULT,
    output logic BLACK_FAULT,
    output logic IRQ
);
    logic fault_log_en_ff;
    logic status_log_en_ff;
    logic stamp_vitc_ff;
    logic [3:0] noise_ff;
    logic [9:0] frz_dur_ff;
    logic [9:0] blk_dur_ff;
    logic [5:0] poll_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic [31:0] rdata_ff;
    logic [27:0] sec_cnt_ff;
    logic [11:0] poll_sec_ff;
    logic poll_due_ff;
    logic query_pend_ff;
    logic fault_pend_ff;
    logic [1:0] last_faults_ff;
    logic msg_valid_ff;
    logic [1:0] msg_kind_ff;
    logic [31:0] msg_stamp_ff;
    logic [23:0] msg_data_ff;
    logic wr_ctrl, wr_cmd, wr_stamp, clear_cmd, query_cmd;
    logic frz_cond, blk_cond, frz_fault, blk_fault;
    logic [31:0] free_stamp;
    logic fault_change, msg_take;

    // Clamp a written value into its legal range
    function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
        clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    assign wr_ctrl = REG_WR && (REG_ADDR == vfm_pkg::OFS_CTRL);
    assign wr_cmd = REG_WR && (REG_ADDR == vfm_pkg::OFS_CMD);
    assign wr_stamp = REG_WR && (REG_ADDR == vfm_pkg::OFS_STAMP);
    assign clear_cmd = wr_cmd && REG_WDATA[vfm_pkg::CMD_CLEAR_BIT];
    assign query_cmd = wr_cmd && REG_WDATA[vfm_pkg::CMD_QUERY_BIT];

    // Control bits: both logs off from reset
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            fault_log_en_ff <= 1'b0;
            status_log_en_ff <= 1'b0;
            stamp_vitc_ff <= 1'b0;
        end else if (wr_ctrl) begin
            fault_log_en_ff <= REG_WDATA[vfm_pkg::CTRL_FAULT_LOG_BIT];
            status_log_en_ff <= REG_WDATA[vfm_pkg::CTRL_STATUS_LOG_BIT];
            stamp_vitc_ff <= REG_WDATA[vfm_pkg::CTRL_STAMP_VITC_BIT];
        end
    end

    // Settings, field bits clamped so out-of-range field values land on the nearest limit; higher write bits are dropped
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            noise_ff <= vfm_pkg::NOISE_RST;
            frz_dur_ff <= vfm_pkg::FRZ_RST;
            blk_dur_ff <= vfm_pkg::BLK_RST;
            poll_ff <= vfm_pkg::POLL_RST;
        end else if (REG_WR) begin
            if (REG_ADDR == vfm_pkg::OFS_NOISE) begin
                noise_ff <= 4'(clamp10({6'h00, REG_WDATA[3:0]}, {6'h00, vfm_pkg::NOISE_MIN},
                    {6'h00, vfm_pkg::NOISE_MAX}));
            end
            if (REG_ADDR == vfm_pkg::OFS_FRZ_DUR) begin
                frz_dur_ff <= clamp10(REG_WDATA[9:0], vfm_pkg::FRZ_MIN, vfm_pkg::FRZ_MAX);
            end
            if (REG_ADDR == vfm_pkg::OFS_BLK_DUR) begin
                blk_dur_ff <= clamp10(REG_WDATA[9:0], vfm_pkg::BLK_MIN, vfm_pkg::BLK_MAX);
            end
            if (REG_ADDR == vfm_pkg::OFS_POLL) begin
                poll_ff <= 6'(clamp10({4'h0, REG_WDATA[5:0]}, {4'h0, vfm_pkg::POLL_MIN},
                    {4'h0, vfm_pkg::POLL_MAX}));
            end
        end
    end

    // Activity at or under noise floor counts toward freeze; peak under 7 IRE toward black
    assign frz_cond = FRAME_ACTIVITY <= 24'(noise_ff) * vfm_pkg::NOISE_STEP;
    assign blk_cond = PEAK_LUMA < vfm_pkg::BLACK_LEVEL;

    vfm_dur_detect u_freeze (
        .ref_clk(REF_CLK),
        .rst(RST),
        .frame_end(FRAME_END),
        .cond(frz_cond),
        .limit(frz_dur_ff),
        .clear(clear_cmd),
        .fault(frz_fault)
    );

    vfm_dur_detect u_black (
        .ref_clk(REF_CLK),
        .rst(RST),
        .frame_end(FRAME_END),
        .cond(blk_cond),
        .limit(blk_dur_ff),
        .clear(clear_cmd),
        .fault(blk_fault)
    );

    vfm_stamp_clock u_stamp (
        .ref_clk(REF_CLK),
        .rst(RST),
        .frame_end(FRAME_END),
        .load(wr_stamp),
        .load_val(REG_WDATA),
        .stamp(free_stamp)
    );

    assign FREEZE_FAULT = frz_fault;
    assign BLACK_FAULT = blk_fault;

    // One-second tick from the reference clock; seconds count toward the poll interval
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sec_cnt_ff <= 28'h0000000;
            poll_sec_ff <= 12'h000;
            poll_due_ff <= 1'b0;
        end else begin
            poll_due_ff <= 1'b0;
            if (sec_cnt_ff == 28'(vfm_pkg::SECOND_TICKS - 1)) begin
                sec_cnt_ff <= 28'h0000000;
                if (poll_sec_ff + 12'h001 >= 12'(poll_ff) * 12'(vfm_pkg::MINUTE_S)) begin
                    poll_sec_ff <= 12'h000;
                    poll_due_ff <= status_log_en_ff;
                end else begin
                    poll_sec_ff <= poll_sec_ff + 12'h001;
                end
            end else begin
                sec_cnt_ff <= sec_cnt_ff + 28'h0000001;
            end
        end
    end

    // Fault change detection against the fault pair stored at the last change, whether logged or not
    assign fault_change = {frz_fault, blk_fault} != last_faults_ff;
    assign msg_take = msg_valid_ff && MSG_READY;

    // Pending requests; a new request wins over the clear of the same cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            query_pend_ff <= 1'b0;
            last_faults_ff <= 2'b00;
            fault_pend_ff <= 1'b0;
        end else begin
            if (query_cmd || poll_due_ff) begin
                query_pend_ff <= 1'b1;
            end else if (!msg_valid_ff && !fault_pend_ff) begin
                query_pend_ff <= 1'b0;
            end
            if (fault_change) begin
                last_faults_ff <= {frz_fault, blk_fault};
                fault_pend_ff <= fault_log_en_ff;
            end else if (!msg_valid_ff) begin
                fault_pend_ff <= 1'b0;
            end
        end
    end

    // Message launcher: fault messages take priority over status reports
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            msg_valid_ff <= 1'b0;
            msg_kind_ff <= 2'h0;
            msg_stamp_ff <= 32'h0000_0000;
            msg_data_ff <= 24'h000000;
        end else if (msg_take || !msg_valid_ff) begin
            msg_valid_ff <= 1'b0;
            if (fault_pend_ff && !msg_take) begin
                msg_valid_ff <= 1'b1;
                msg_kind_ff <= vfm_pkg::VFM_MSG_FAULT;
                msg_stamp_ff <= (stamp_vitc_ff && VITC_VALID) ? VITC_TIME : free_stamp;
                msg_data_ff <= {22'h000000, last_faults_ff};
            end else if (query_pend_ff && !msg_take) begin
                msg_valid_ff <= 1'b1;
                msg_kind_ff <= vfm_pkg::VFM_MSG_STATUS;
                msg_stamp_ff <= free_stamp;
                msg_data_ff <= {STATUS_ITEMS, EDH_AP_ERR, EDH_FF_ERR, AUDIO_FMT_ERR, 3'h0,
                    frz_fault, blk_fault};
            end
        end
    end

    assign MSG_VALID = msg_valid_ff;
    assign MSG_KIND = msg_kind_ff;
    assign MSG_STAMP = msg_stamp_ff;
    assign MSG_DATA = msg_data_ff;

    // Sticky interrupt bits, write one to clear; a new event wins over the clear
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (REG_WR && REG_ADDR == vfm_pkg::OFS_IRQ_STAT && REG_WDATA[i]) begin
                    irq_stat_ff[i] <= 1'b0;
                end
            end
            if (frz_fault && !last_faults_ff[1]) begin
                irq_stat_ff[vfm_pkg::IRQ_FRZ_BIT] <= 1'b1;
            end
            if (blk_fault && !last_faults_ff[0]) begin
                irq_stat_ff[vfm_pkg::IRQ_BLK_BIT] <= 1'b1;
            end
            if (msg_take) begin
                irq_stat_ff[vfm_pkg::IRQ_MSG_BIT] <= 1'b1;
            end
            if (REG_WR && REG_ADDR == vfm_pkg::OFS_IRQ_MASK) begin
                irq_mask_ff <= REG_WDATA[2:0];
            end
        end
    end

    assign IRQ = |(irq_stat_ff & irq_mask_ff);

    // Read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_ff <= 32'h0000_0000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                vfm_pkg::OFS_CTRL: rdata_ff <= {29'h0, stamp_vitc_ff, status_log_en_ff, fault_log_en_ff};
                vfm_pkg::OFS_NOISE: rdata_ff <= {28'h0, noise_ff};
                vfm_pkg::OFS_FRZ_DUR: rdata_ff <= {22'h0, frz_dur_ff};
                vfm_pkg::OFS_BLK_DUR: rdata_ff <= {22'h0, blk_dur_ff};
                vfm_pkg::OFS_POLL: rdata_ff <= {26'h0, poll_ff};
                vfm_pkg::OFS_STAMP: rdata_ff <= free_stamp;
                vfm_pkg::OFS_STATUS: rdata_ff <= {30'h0, frz_fault, blk_fault};
                vfm_pkg::OFS_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
                vfm_pkg::OFS_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign REG_RDATA = rdata_ff;

    a_logs_off_reset: assert property (@(posedge REF_CLK) disable iff (RST)
        $fell(RST) |-> !fault_log_en_ff && !status_log_en_ff) else $error("Log enabled after reset");
    a_query_sends: assert property (@(posedge REF_CLK) disable iff (RST)
        (query_cmd && !msg_valid_ff && !fault_change && !fault_pend_ff) |-> ##[1:3] MSG_VALID)
        else $error("Query gave no report");
    a_fault_msg_gated: assert property (@(posedge REF_CLK) disable iff (RST)
        (MSG_VALID && MSG_KIND == vfm_pkg::VFM_MSG_FAULT && !$past(MSG_VALID)) |-> $past(fault_log_en_ff, 2))
        else $error("Fault message while disabled");
    a_stamp_source: assert property (@(posedge REF_CLK) disable iff (RST)
        ($rose(MSG_VALID) && MSG_KIND == vfm_pkg::VFM_MSG_FAULT && $past(stamp_vitc_ff && VITC_VALID))
        |-> MSG_STAMP == $past(VITC_TIME)) else $error("Wrong stamp source");
    a_noise_range: assert property (@(posedge REF_CLK) disable iff (RST)
        noise_ff >= vfm_pkg::NOISE_MIN && noise_ff <= vfm_pkg::NOISE_MAX) else $error("Noise out of range");
    a_poll_range: assert property (@(posedge REF_CLK) disable iff (RST)
        poll_ff >= vfm_pkg::POLL_MIN && poll_ff <= vfm_pkg::POLL_MAX) else $error("Poll out of range");
endmodule // vfm_monitor

/* File: bench/vfm_msg_sink.sv */
// Serial logging host: takes one message per handshake, promptly or slowly
module vfm_msg_sink (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic msg_valid,
    input wire logic [1:0] msg_kind,
    input wire logic [31:0] msg_stamp,
    input wire logic [23:0] msg_data,
    output logic msg_ready,
    output logic [7:0] cnt_ff,
    output logic [1:0] kind_ff,
    output logic [31:0] stamp_ff,
    output logic [23:0] data_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick_ff;

    // Slow mode accepts one cycle in four, so the sender must hold its message
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_ff <= 2'h0;
            msg_ready <= 1'b0;
            cnt_ff <= 8'h00;
            kind_ff <= 2'h0;
            stamp_ff <= 32'h0;
            data_ff <= 24'h0;
        end else begin
            tick_ff <= tick_ff + 2'h1;
            msg_ready <= !slow || (tick_ff == 2'h3);
            if (msg_valid && msg_ready) begin
                cnt_ff <= cnt_ff + 8'h01;
                kind_ff <= msg_kind;
                stamp_ff <= msg_stamp;
                data_ff <= msg_data;
            end
        end
    end
endmodule // vfm_msg_sink

/* File: bench/tb_top.sv */
// Self-checking bench for the video fault monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK, RST, FRAME_END, VITC_VALID, EDH_AP_ERR, EDH_FF_ERR, AUDIO_FMT_ERR;
    logic REG_WR, REG_RD, MSG_VALID, MSG_READY, FREEZE_FAULT, BLACK_FAULT, IRQ, slow;
    logic [23:0] FRAME_ACTIVITY, MSG_DATA, s_data;
    logic [9:0] PEAK_LUMA;
    logic [31:0] VITC_TIME, REG_WDATA, REG_RDATA, MSG_STAMP, s_stamp, rnd, d;
    logic [15:0] STATUS_ITEMS;
    logic [7:0] REG_ADDR, s_cnt;
    logic [1:0] MSG_KIND, s_kind;
    int fail_count = 0;
    int tests_run = 0;

    vfm_monitor vfm_monitor_inst (.REF_CLK(REF_CLK), .RST(RST), .FRAME_END(FRAME_END),
        .FRAME_ACTIVITY(FRAME_ACTIVITY), .PEAK_LUMA(PEAK_LUMA), .VITC_VALID(VITC_VALID),
        .VITC_TIME(VITC_TIME), .STATUS_ITEMS(STATUS_ITEMS), .EDH_AP_ERR(EDH_AP_ERR),
        .EDH_FF_ERR(EDH_FF_ERR), .AUDIO_FMT_ERR(AUDIO_FMT_ERR), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY), .MSG_KIND(MSG_KIND), .MSG_STAMP(MSG_STAMP),
        .MSG_DATA(MSG_DATA), .FREEZE_FAULT(FREEZE_FAULT), .BLACK_FAULT(BLACK_FAULT), .IRQ(IRQ));
    vfm_msg_sink vfm_msg_sink_inst (.ref_clk(REF_CLK), .rst(RST), .slow(slow), .msg_valid(MSG_VALID),
        .msg_kind(MSG_KIND), .msg_stamp(MSG_STAMP), .msg_data(MSG_DATA), .msg_ready(MSG_READY),
        .cnt_ff(s_cnt), .kind_ff(s_kind), .stamp_ff(s_stamp), .data_ff(s_data));

    // Free-running clock, 4 ns period
    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end

    // Galois shift register keeps the random stream repeatable
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge REF_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge REF_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 v = REG_RDATA;
    endtask

    task automatic frames(input int n, input logic [23:0] act, input logic [9:0] luma);
        repeat (n) begin
            @(posedge REF_CLK);
            FRAME_END <= 1'b1;
            FRAME_ACTIVITY <= act;
            PEAK_LUMA <= luma;
            @(posedge REF_CLK);
            FRAME_END <= 1'b0;
            repeat (3) @(posedge REF_CLK);
        end
        #1;
    endtask

    // Bounded wait for the host to have taken n messages
    task automatic wait_msg(input logic [7:0] n);
        int i;
        i = 0;
        while (s_cnt !== n && i < 200) begin
            @(posedge REF_CLK);
            i++;
        end
        #1 chk("msg count", s_cnt, n);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #40000;
        fail_count++;
        end_sim();
    end

    // Reset values and clamp table
    logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rv[5] = '{32'h0, 32'h9, 32'd302, 32'd88, 32'h1};
    logic [7:0] ca[8] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h10, 8'h10};
    logic [31:0] cw[8] = '{32'd0, 32'd11, 32'd5, 32'd903, 32'd3, 32'd901, 32'd0, 32'd61};
    logic [31:0] ce[8] = '{32'(vfm_pkg::NOISE_MIN), 32'(vfm_pkg::NOISE_MAX), 32'(vfm_pkg::FRZ_MIN),
        32'(vfm_pkg::FRZ_MAX), 32'(vfm_pkg::BLK_MIN), 32'(vfm_pkg::BLK_MAX), 32'(vfm_pkg::POLL_MIN),
        32'(vfm_pkg::POLL_MAX)};

    initial begin
        {RST, FRAME_END, VITC_VALID, EDH_AP_ERR, EDH_FF_ERR, AUDIO_FMT_ERR, REG_WR, REG_RD, slow} = 9'h100;
        {FRAME_ACTIVITY, PEAK_LUMA, VITC_TIME, REG_WDATA, STATUS_ITEMS, REG_ADDR} = '0;
        rnd = 32'h2a64;
        repeat (16) @(posedge REF_CLK);
        RST <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], d);
            chk("reset value", d, rv[i]);
        end
        for (int i = 0; i < 8; i++) begin
            wr(ca[i], cw[i]);
            rd(ca[i], d);
            chk("clamped setting", d, ce[i]);
        end
        rd(8'h28, d);
        chk("unmapped read", d, 32'h0);
        $display("test registers done");
        // Freeze at noise 1, six frames; one busy frame restarts the count
        wr(vfm_pkg::OFS_NOISE, 32'h1);
        wr(vfm_pkg::OFS_FRZ_DUR, 32'd6);
        frames(5, 24'h000400, 10'h3ff);
        chk("freeze early", FREEZE_FAULT, 1'b0);
        rnd = lfsr(rnd);
        frames(1, rnd[23:0] | 24'h000401, 10'h3ff);
        frames(5, 24'h000400, 10'h3ff);
        chk("freeze restarted", FREEZE_FAULT, 1'b0);
        frames(1, 24'h000400, 10'h3ff);
        chk("freeze set", FREEZE_FAULT, 1'b1);
        chk("no msg log off", s_cnt, 8'h0);
        $display("test freeze done");
        // Sticky status, mask, write-one-to-clear
        rd(vfm_pkg::OFS_IRQ_STAT, d);
        chk("irq status", d, 32'h1);
        chk("irq masked", IRQ, 1'b0);
        wr(vfm_pkg::OFS_IRQ_MASK, 32'h1);
        #1 chk("irq raised", IRQ, 1'b1);
        wr(vfm_pkg::OFS_IRQ_STAT, 32'h1);
        #1 chk("irq cleared", IRQ, 1'b0);
        $display("test irq done");
        // Loaded stamp clock stamps the clear message
        wr(vfm_pkg::OFS_STAMP, 32'h01020304);
        rd(vfm_pkg::OFS_STAMP, d);
        chk("stamp load", d, 32'h01020304);
        wr(vfm_pkg::OFS_CTRL, 32'h1);
        wr(vfm_pkg::OFS_CMD, 32'h2);
        wait_msg(8'h1);
        chk("freeze cleared", FREEZE_FAULT, 1'b0);
        chk("clear msg", {s_kind, s_data}, {vfm_pkg::VFM_MSG_FAULT, 24'h0});
        chk("free stamp", s_stamp, 32'h01020304);
        $display("test clear done");
        // Black at the 7 IRE boundary, stamped from VITC, slow host
        @(posedge REF_CLK);
        slow <= 1'b1;
        rnd = lfsr(rnd);
        VITC_VALID <= 1'b1;
        VITC_TIME <= rnd;
        wr(vfm_pkg::OFS_CTRL, 32'h5);
        wr(vfm_pkg::OFS_BLK_DUR, 32'd4);
        frames(3, 24'hffffff, vfm_pkg::BLACK_LEVEL - 10'h001);
        chk("black early", BLACK_FAULT, 1'b0);
        frames(1, 24'hffffff, vfm_pkg::BLACK_LEVEL - 10'h001);
        chk("black set", BLACK_FAULT, 1'b1);
        wait_msg(8'h2);
        chk("black msg", {s_kind, s_data}, {vfm_pkg::VFM_MSG_FAULT, 24'h1});
        chk("vitc stamp", s_stamp, rnd);
        $display("test black done");
        // Queries with status log off, random status items
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            @(posedge REF_CLK);
            STATUS_ITEMS <= rnd[15:0];
            {EDH_AP_ERR, EDH_FF_ERR, AUDIO_FMT_ERR} <= rnd[18:16];
            wr(vfm_pkg::OFS_CMD, 32'h1);
            wait_msg(8'h3 + 8'(i));
            chk("status msg", {s_kind, s_data},
                {vfm_pkg::VFM_MSG_STATUS, rnd[15:0], rnd[18:16], 5'h01});
        end
        $display("test query done");
        end_sim();
    end
endmodule // tb_top
